// File: cpic_instr_ctrl.sv
`timescale 1ns/1ps
module cpic_instr_ctrl (
	input  wire logic                     clock,
	input  wire logic                     rst,
	input  wire logic                     xchgValid,
	input  wire logic [2:0]               xchgIndex,
	input  wire logic [cpic_pkg::XW-1:0]  xchgWord,
	input  wire logic                     xchgDone,
	input  wire logic                     msAck,
	input  wire logic [cpic_pkg::XW-1:0]  msRdata,
	input  wire logic                     errCpuToCtrl,
	input  wire logic                     errCtrlToCpu,
	input  wire logic                     errFlagParity,
	output logic                          msReq,
	output logic                          msWe,
	output logic [cpic_pkg::AW-1:0]       msAddr,
	output logic [cpic_pkg::XW-1:0]       msWdata,
	output logic [cpic_pkg::XW-1:0]       xchgOldWord,
	output logic                          running,
	output logic                          errorExit,
	output logic [cpic_pkg::EXW-1:0]      errorCause,
	output logic [cpic_pkg::AW-1:0]       instrCounter,
	output logic [cpic_pkg::AW-1:0]       mainStoreBase,
	output logic [cpic_pkg::AW-1:0]       mainStoreLimit,
	output logic [cpic_pkg::EXW-1:0]      exitSelect,
	output logic [cpic_pkg::EBW-1:0]      extBase,
	output logic [cpic_pkg::ELW-1:0]      extLimit,
	output logic [cpic_pkg::AW-1:0]       monitorPkgPtr,
	output logic [cpic_pkg::EBW-1:0]      extAbsAddr,
	output logic                          extOutOfRange
);
	import cpic_pkg::*;

	// ==========================================================
	// Functions
	function automatic logic [PARCEL_W-1:0] parcelOf(input logic [XW-1:0] w, input logic [1:0] idx);
		return w[XW-1-PARCEL_W*idx -: PARCEL_W];
	endfunction : parcelOf

	function automatic logic [CNT_W-1:0] popCount(input logic [XW-1:0] x);
		logic [CNT_W-1:0] n;
		n = '0;
		for (int b = 0; b < XW; b++) n = n + CNT_W'(x[b]);
		return n;
	endfunction : popCount

	function automatic logic [5:0] leadZeros(input logic [COEF_W-1:0] c);
		logic [5:0] n;
		logic       hit;
		n = 6'(COEF_W);
		hit = 1'b0;
		for (int b = COEF_W-1; b >= 0; b--) begin
			if (!hit && c[b]) begin
				n = 6'(COEF_W-1-b);
				hit = 1'b1;
			end
		end
		return n;
	endfunction : leadZeros

	function automatic logic [XW-1:0] rotLeft(input logic [XW-1:0] x, input logic [SH_W-1:0] n);
		logic [2*XW-1:0] d;
		logic [SH_W-1:0] m;
		m = (n >= SH_W'(XW)) ? n - SH_W'(XW) : n;
		d = {x, x} << m;
		return d[2*XW-1:XW];
	endfunction : rotLeft

	function automatic logic isExp(input logic [XW-1:0] x, input logic [EXP_W-1:0] e);
		return (x[EXP_HI:EXP_LO] == e) || (x[EXP_HI:EXP_LO] == ~e);
	endfunction : isExp

	function automatic logic [XW-1:0] fpAdd(input logic [XW-1:0] a, input logic [XW-1:0] b,
	                                        input logic sub, input logic rnd);
		logic [EXP_W-1:0]  e;
		logic [COEF_W:0]   ca;
		logic [COEF_W:0]   cb;
		logic [COEF_W:0]   s;
		logic              sg;
		ca = {1'b0, a[COEF_W-1:0]};
		cb = {1'b0, b[COEF_W-1:0]};
		sg = a[SIGN_POS];
		if (a[EXP_HI:EXP_LO] >= b[EXP_HI:EXP_LO]) begin
			e = a[EXP_HI:EXP_LO];
			cb = cb >> (a[EXP_HI:EXP_LO] - b[EXP_HI:EXP_LO]);
		end else begin
			e = b[EXP_HI:EXP_LO];
			ca = ca >> (b[EXP_HI:EXP_LO] - a[EXP_HI:EXP_LO]);
		end
		if (!sub) s = ca + cb;
		else if (ca >= cb) s = ca - cb;
		else begin
			s = cb - ca;
			sg = ~sg;
		end
		if (s[COEF_W]) begin
			s = s >> 1;
			e = e + 11'h1;
		end
		s = s + {{COEF_W{1'b0}}, rnd};
		return {sg, e, s[COEF_W-1:0]};
	endfunction : fpAdd

	function automatic logic [XW-1:0] fpMul(input logic [XW-1:0] a, input logic [XW-1:0] b,
	                                        input logic rnd, input logic dbl);
		logic [2*COEF_W-1:0] prod;
		logic [COEF_W-1:0]   c;
		logic [EXP_W-1:0]    e;
		prod = a[COEF_W-1:0] * b[COEF_W-1:0];
		c = dbl ? prod[COEF_W-1:0] : prod[2*COEF_W-1:COEF_W] + {{(COEF_W-1){1'b0}}, rnd & prod[COEF_W-1]};
		e = a[EXP_HI:EXP_LO] + b[EXP_HI:EXP_LO] + (dbl ? 11'h0 : 11'(COEF_W));
		return {a[SIGN_POS] ^ b[SIGN_POS], e, c};
	endfunction : fpMul

	function automatic logic [XW-1:0] fpDiv(input logic [XW-1:0] a, input logic [XW-1:0] b, input logic rnd);
		logic [2*COEF_W-1:0] q;
		logic [EXP_W-1:0]    e;
		// Zero divisor gives an all-ones quotient for FDIV (the RFDIV round bit wraps it to zero) rather than stalling the sequence
		if (b[COEF_W-1:0] == '0) q = '1;
		else q = {a[COEF_W-1:0], {COEF_W{1'b0}}} / {{COEF_W{1'b0}}, b[COEF_W-1:0]};
		q = q + {{(2*COEF_W-1){1'b0}}, rnd};
		e = a[EXP_HI:EXP_LO] - b[EXP_HI:EXP_LO] - 11'(COEF_W);
		return {a[SIGN_POS] ^ b[SIGN_POS], e, q[COEF_W-1:0]};
	endfunction : fpDiv

	// ==========================================================
	// Storage
	logic [XW-1:0]  xReg_ff [8];
	logic [AW-1:0]  aReg_ff [8];
	logic [AW-1:0]  bReg_ff [8];
	logic [AW-1:0]  progCnt_ff, base_ff, limit_ff, mon_ff;
	logic [EXW-1:0] exSel_ff, cause_ff;
	logic [EBW-1:0] extBase_ff, extAbs_ff;
	logic [ELW-1:0] extLimit_ff;
	logic [XW-1:0]  ciw_ff, wdata_ff, xchgOld_ff;
	logic [1:0]     parIdx_ff;
	logic [AW-1:0]  addr_ff;
	logic [2:0]     memTgt_ff;
	logic           req_ff, we_ff, memFetch_ff, err_ff, extOor_ff;
	cpic_state_t    state_ff;

	// ==========================================================
	// Decode and execute
	logic [PARCEL_W-1:0] par;
	logic [5:0]          op;
	logic [2:0]          ri, rj, rk, bDst;
	logic [AW-1:0]       kk, aRes, bRes, ptrAbs, fetchAbs;
	logic [XW-1:0]       xi, xj, xk, xRes, normRes;
	logic [5:0]          nz;
	logic                wide, last, xWr, aWr, bWr, isFloat, oor, useTgt, issue, commit, errAny;
	logic                memStart, fetchStart;
	logic [EXW-1:0]      errVec;

	always_comb begin
		// Parcels picked from the top of the word downward
		// parcel select
		par = parcelOf(ciw_ff, parIdx_ff);
		op = par[14:9];
		ri = par[8:6];
		rj = par[5:3];
		rk = par[2:0];
		kk = {rk, parcelOf(ciw_ff, parIdx_ff + 2'h1)};
		xi = xReg_ff[ri];
		xj = xReg_ff[rj];
		xk = xReg_ff[rk];
		wide = (op == OP_SETA) || (op == OP_SETB);
		last = (parIdx_ff == 2'h3) || (wide && parIdx_ff == 2'h2);
		nz = leadZeros(xk[COEF_W-1:0]);
		normRes = {xk[SIGN_POS], xk[EXP_HI:EXP_LO] - 11'(nz),
		           (xk[COEF_W-1:0] << nz) | ((op == OP_RNORM) ? ((48'h1 << nz) >> 1) : 48'h0)};
		xRes = '0;
		aRes = aReg_ff[rj] + kk;
		bRes = '0;
		bDst = rj;
		xWr = 1'b1;
		aWr = 1'b0;
		bWr = 1'b0;
		isFloat = 1'b0;
		unique case (op)
			OP_XJ: xRes = xj;
			OP_XK: xRes = xk;
			OP_AND:  xRes = xj & xk;
			OP_OR:   xRes = xj | xk;
			OP_XOR:  xRes = xj ^ xk;
			OP_ANDN: xRes = xj & ~xk;
			OP_ORN:  xRes = xj | ~xk;
			OP_XORN: xRes = xj ^ ~xk;
			OP_LSH:  xRes = rotLeft(xi, {rj, rk});
			OP_RSH:  xRes = XW'($signed(xi) >>> {rj, rk});
			OP_LSHB: xRes = bReg_ff[rj][AW-1] ? XW'($signed(xk) >>> ~bReg_ff[rj][SH_W-1:0])
			                                  : rotLeft(xk, bReg_ff[rj][SH_W-1:0]);
			OP_RSHB: xRes = bReg_ff[rj][AW-1] ? rotLeft(xk, ~bReg_ff[rj][SH_W-1:0])
			                                  : XW'($signed(xk) >>> bReg_ff[rj][SH_W-1:0]);
			OP_MASK: xRes = ~({XW{1'b1}} >> {rj, rk});
			OP_NORM, OP_RNORM: begin
				xRes = normRes;
				bRes = AW'(nz);
				bWr = 1'b1;
			end
			OP_UNPK: begin
				xRes = {{(XW-COEF_W){xk[SIGN_POS]}}, xk[COEF_W-1:0]};
				bRes = {{(AW-EXP_W){xk[EXP_HI]}}, xk[EXP_HI:EXP_LO]};
				bWr = 1'b1;
			end
			OP_PACK: xRes = {xk[SIGN_POS], bReg_ff[rj][EXP_W-1:0], xk[COEF_W-1:0]};
			6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c, OP_RFSUB: begin
				xRes = fpAdd(xj, xk, op[0], op >= 6'h1c);
				isFloat = 1'b1;
			end
			OP_FMUL, OP_RFMUL, OP_DFMUL: begin
				xRes = fpMul(xj, xk, op == OP_RFMUL, op == OP_DFMUL);
				isFloat = 1'b1;
			end
			OP_FDIV, OP_RFDIV: begin
				xRes = fpDiv(xj, xk, op == OP_RFDIV);
				isFloat = 1'b1;
			end
			OP_POP: xRes = XW'(popCount(xk));
			OP_SETA: begin
				xWr = 1'b0;
				aWr = !last || parIdx_ff != 2'h3;
			end
			OP_SETB: begin
				xWr = 1'b0;
				bRes = bReg_ff[rj] + kk;
				bDst = ri;
				bWr = parIdx_ff != 2'h3;
			end
			default: xWr = 1'b0;
		endcase
	end

	assign ptrAbs = base_ff + aRes;
	assign fetchAbs = base_ff + progCnt_ff;
	assign oor = aRes >= limit_ff;
	assign useTgt = req_ff && !we_ff && !memFetch_ff && (ri == memTgt_ff || rj == memTgt_ff || rk == memTgt_ff);
	assign issue = (state_ff == ST_RUN) && !useTgt && !(aWr && req_ff);
	assign errVec[EX_RANGE] = (issue && aWr && ri != 3'h0 && oor && exSel_ff[EX_RANGE])
	                          || (state_ff == ST_FETCH && !req_ff && progCnt_ff >= limit_ff);
	assign errVec[EX_INF]   = issue && isFloat && (isExp(xj, EXP_INF) || isExp(xk, EXP_INF)) && exSel_ff[EX_INF];
	assign errVec[EX_INDEF] = issue && isFloat && (isExp(xj, EXP_INDEF) || isExp(xk, EXP_INDEF)) && exSel_ff[EX_INDEF];
	assign errVec[EX_FLAG]  = errFlagParity && exSel_ff[EX_FLAG];
	assign errVec[EX_C2M]   = errCpuToCtrl && exSel_ff[EX_C2M];
	assign errVec[EX_M2C]   = errCtrlToCpu && msAck && exSel_ff[EX_M2C];
	assign errAny = (state_ff == ST_RUN || state_ff == ST_FETCH) && (errVec != '0);
	assign commit = issue && !errAny;
	assign memStart = commit && aWr && ri != 3'h0 && !oor;
	assign fetchStart = (state_ff == ST_FETCH) && !req_ff && !errAny;

	// ==========================================================
	// Sequencing
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_ff <= ST_IDLE;
		end else if (errAny) begin
			state_ff <= ST_HALT;
		end else if (xchgValid) begin
			state_ff <= ST_IDLE;
		end else if (xchgDone) begin
			state_ff <= ST_FETCH;
		end else if (state_ff == ST_FETCH && msAck && memFetch_ff) begin
			state_ff <= ST_RUN;
		end else if (commit && last) begin
			state_ff <= ST_FETCH;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ciw_ff <= '0;
			parIdx_ff <= '0;
		end else if (msAck && memFetch_ff) begin
			ciw_ff <= msRdata;
			parIdx_ff <= '0;
		end else if (commit && !last) begin
			parIdx_ff <= parIdx_ff + (wide ? 2'h2 : 2'h1);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			err_ff <= 1'b0;
			cause_ff <= '0;
		end else if (errAny) begin
			err_ff <= 1'b1;
			cause_ff <= errVec;
		end else if (xchgValid) begin
			err_ff <= 1'b0;
			cause_ff <= '0;
		end
	end

	// ==========================================================
	// Store references
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_ff <= 1'b0;
			we_ff <= 1'b0;
			memFetch_ff <= 1'b0;
			memTgt_ff <= '0;
			addr_ff <= '0;
			wdata_ff <= '0;
		end else if (msAck) begin
			req_ff <= 1'b0;
		end else if (fetchStart) begin
			req_ff <= 1'b1;
			we_ff <= 1'b0;
			memFetch_ff <= 1'b1;
			addr_ff <= fetchAbs;
		// write on pointer 6 or 7
		end else if (memStart) begin
			req_ff <= 1'b1;
			we_ff <= ri >= FIRST_WRITE_PTR;
			memFetch_ff <= 1'b0;
			memTgt_ff <= ri;
			addr_ff <= ptrAbs;
			wdata_ff <= xi;
		end
	end

	// ==========================================================
	// Operating registers
	// operand registers with read fill
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int n = 0; n < 8; n++) xReg_ff[n] <= '0;
		end else begin
			if (msAck && !memFetch_ff && !we_ff) xReg_ff[memTgt_ff] <= msRdata;
			if (commit && xWr) xReg_ff[ri] <= xRes;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int n = 0; n < 8; n++) aReg_ff[n] <= '0;
		end else if (commit && aWr) begin
			aReg_ff[ri] <= aRes;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int n = 0; n < 8; n++) bReg_ff[n] <= '0;
		end else if (commit && bWr && bDst != 3'h0) begin
			bReg_ff[bDst] <= bRes;
		end
	end

	// ==========================================================
	// Support registers, written by exchange; the counter also steps on each fetch
	// exchange load and store back
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			progCnt_ff <= '0;
			base_ff <= '0;
			limit_ff <= '0;
			exSel_ff <= '0;
			extBase_ff <= '0;
			extLimit_ff <= '0;
			mon_ff <= '0;
			xchgOld_ff <= '0;
		end else if (xchgValid) begin
			unique case (xchgIndex)
				XI_CNT: begin
					xchgOld_ff <= XW'(progCnt_ff);
					progCnt_ff <= xchgWord[AW-1:0];
				end
				XI_MSB: begin
					xchgOld_ff <= XW'(base_ff);
					base_ff <= xchgWord[AW-1:0];
				end
				XI_MSL: begin
					xchgOld_ff <= XW'(limit_ff);
					limit_ff <= xchgWord[AW-1:0];
				end
				XI_SEL: begin
					xchgOld_ff <= XW'({exSel_ff[5:3], {(SEL_HI_POS-SEL_LO_POS-3){1'b0}}, exSel_ff[2:0]}) << SEL_LO_POS;
					exSel_ff <= {xchgWord[SEL_HI_POS+2:SEL_HI_POS], xchgWord[SEL_LO_POS+2:SEL_LO_POS]};
				end
				XI_EXB: begin
					xchgOld_ff <= XW'(extBase_ff);
					extBase_ff <= {xchgWord[EBW-1:EXT_ZERO], {EXT_ZERO{1'b0}}};
				end
				XI_EXL: begin
					xchgOld_ff <= XW'(extLimit_ff);
					extLimit_ff <= {xchgWord[ELW-1:EXT_ZERO], {EXT_ZERO{1'b0}}};
				end
				XI_MON: begin
					xchgOld_ff <= XW'(mon_ff);
					mon_ff <= xchgWord[AW-1:0];
				end
				default: xchgOld_ff <= '0;
			endcase
		end else if (msAck && memFetch_ff) begin
			progCnt_ff <= progCnt_ff + 18'h1;
		end
	end

	// Extended address formed from operand 0; registered and driven out on extAbsAddr
	// extended absolute address
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			extAbs_ff <= '0;
			extOor_ff <= 1'b0;
		end else begin
			extAbs_ff <= extBase_ff + xReg_ff[0][EBW-1:0];
			extOor_ff <= xReg_ff[0][ELW-1:0] >= extLimit_ff;
		end
	end

	assign msReq = req_ff;
	assign msWe = we_ff;
	assign msAddr = addr_ff;
	assign msWdata = wdata_ff;
	assign xchgOldWord = xchgOld_ff;
	assign running = (state_ff == ST_RUN);
	assign errorExit = err_ff;
	assign errorCause = cause_ff;
	assign instrCounter = progCnt_ff;
	assign mainStoreBase = base_ff;
	assign mainStoreLimit = limit_ff;
	assign exitSelect = exSel_ff;
	assign extBase = extBase_ff;
	assign extLimit = extLimit_ff;
	assign monitorPkgPtr = mon_ff;
	assign extAbsAddr = extAbs_ff;
	assign extOutOfRange = extOor_ff;

	// ==========================================================
	// Assertions
	default clocking cbk @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_ptrRead;
		memStart && ri <= 3'h5;
	endsequence
	sequence s_readDone;
		req_ff && msAck && !we_ff && !memFetch_ff;
	endsequence
	property p_ptrRead;
		s_ptrRead |=> req_ff && !we_ff && addr_ff == $past(ptrAbs) && memTgt_ff == $past(ri);
	endproperty
	a_ptrRead: assert property (p_ptrRead) else $error("pointer load did not start read");
	property p_readFill;
		s_readDone |=> xReg_ff[$past(memTgt_ff)] == $past(msRdata);
	endproperty
	a_readFill: assert property (p_readFill) else $error("read word not delivered");
	property p_ptrWrite;
		memStart && ri >= FIRST_WRITE_PTR |=> req_ff && we_ff && wdata_ff == $past(xi);
	endproperty
	a_ptrWrite: assert property (p_ptrWrite) else $error("pointer 6/7 load did not write");
	property p_b0Zero;
		bReg_ff[0] == '0;
	endproperty
	a_b0Zero: assert property (p_b0Zero) else $error("index 0 not zero");
	property p_fetchAddr;
		fetchStart |=> req_ff && memFetch_ff && addr_ff == $past(fetchAbs);
	endproperty
	a_fetchAddr: assert property (p_fetchAddr) else $error("fetch address wrong");
	property p_rangeExit;
		issue && aWr && ri != 3'h0 && oor && exSel_ff[EX_RANGE] |=> err_ff && cause_ff[EX_RANGE] && state_ff == ST_HALT;
	endproperty
	a_rangeExit: assert property (p_rangeExit) else $error("range exit missed");
	property p_support;
		!xchgValid |=> $stable(base_ff) && $stable(limit_ff) && $stable(exSel_ff) && $stable(mon_ff)
		            && $stable(extBase_ff) && $stable(extLimit_ff);
	endproperty
	a_support: assert property (p_support) else $error("support register changed");
	property p_hold;
		state_ff == ST_RUN && useTgt && !msAck |=> $stable(parIdx_ff) && state_ff != ST_FETCH;
	endproperty
	a_hold: assert property (p_hold) else $error("issued past pending read");
	property p_pop;
		commit && op == OP_POP |=> xReg_ff[$past(ri)] == XW'(popCount($past(xk)));
	endproperty
	a_pop: assert property (p_pop) else $error("population count wrong");
	property p_selLoad;
		xchgValid && xchgIndex == XI_SEL |=> exSel_ff == {$past(xchgWord[59:57]), $past(xchgWord[50:48])};
	endproperty
	a_selLoad: assert property (p_selLoad) else $error("exit select load wrong");
endmodule : cpic_instr_ctrl

// File: cpic_pkg.sv
// Shared constants and types for the processor instruction control block
package cpic_pkg;
	localparam int XW       = 60;
	localparam int AW       = 18;
	localparam int EBW      = 21;
	localparam int ELW      = 24;
	localparam int EXW      = 6;
	localparam int EXT_ZERO = 6;
	localparam int COEF_W   = 48;
	localparam int EXP_W    = 11;
	localparam int EXP_LO   = 48;
	localparam int EXP_HI   = 58;
	localparam int SIGN_POS = 59;
	localparam int PARCEL_W = 15;
	localparam int CNT_W    = 7;
	localparam int SH_W     = 6;
	// Exchange word positions, first word is index 0
	localparam logic [2:0] XI_CNT = 3'h0;
	localparam logic [2:0] XI_MSB = 3'h1;
	localparam logic [2:0] XI_MSL = 3'h2;
	localparam logic [2:0] XI_SEL = 3'h3;
	localparam logic [2:0] XI_EXB = 3'h4;
	localparam logic [2:0] XI_EXL = 3'h5;
	localparam logic [2:0] XI_MON = 3'h6;
	localparam int SEL_LO_POS = 48;
	localparam int SEL_HI_POS = 57;
	// Exit select bit numbers
	localparam int EX_RANGE = 0;
	localparam int EX_INF   = 1;
	localparam int EX_INDEF = 2;
	localparam int EX_FLAG  = 3;
	localparam int EX_C2M   = 4;
	localparam int EX_M2C   = 5;
	localparam logic [EXP_W-1:0] EXP_INF   = 11'h7ff;
	localparam logic [EXP_W-1:0] EXP_INDEF = 11'h3ff;
	localparam logic [2:0] FIRST_WRITE_PTR = 3'h6;
	// Opcodes
	localparam logic [5:0] OP_XJ    = 6'h08;
	localparam logic [5:0] OP_AND   = 6'h09;
	localparam logic [5:0] OP_OR    = 6'h0a;
	localparam logic [5:0] OP_XOR   = 6'h0b;
	localparam logic [5:0] OP_XK    = 6'h0c;
	localparam logic [5:0] OP_ANDN  = 6'h0d;
	localparam logic [5:0] OP_ORN   = 6'h0e;
	localparam logic [5:0] OP_XORN  = 6'h0f;
	localparam logic [5:0] OP_LSH   = 6'h10;
	localparam logic [5:0] OP_RSH   = 6'h11;
	localparam logic [5:0] OP_LSHB  = 6'h12;
	localparam logic [5:0] OP_RSHB  = 6'h13;
	localparam logic [5:0] OP_NORM  = 6'h14;
	localparam logic [5:0] OP_RNORM = 6'h15;
	localparam logic [5:0] OP_UNPK  = 6'h16;
	localparam logic [5:0] OP_PACK  = 6'h17;
	localparam logic [5:0] OP_FADD  = 6'h18;
	localparam logic [5:0] OP_RFSUB = 6'h1d;
	localparam logic [5:0] OP_FMUL  = 6'h20;
	localparam logic [5:0] OP_RFMUL = 6'h21;
	localparam logic [5:0] OP_DFMUL = 6'h22;
	localparam logic [5:0] OP_MASK  = 6'h23;
	localparam logic [5:0] OP_FDIV  = 6'h24;
	localparam logic [5:0] OP_RFDIV = 6'h25;
	localparam logic [5:0] OP_POP   = 6'h27;
	localparam logic [5:0] OP_SETA  = 6'h28;
	localparam logic [5:0] OP_SETB  = 6'h31;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_RUN, ST_HALT} cpic_state_t;
endpackage : cpic_pkg

// File: cpic_store_model.sv
// Main store controller model, one reference at a time
`timescale 1ns/1ps
module cpic_store_model #(
	parameter int LAT = 2
) (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    msReq,
	input  wire logic                    msWe,
	input  wire logic [cpic_pkg::AW-1:0] msAddr,
	input  wire logic [cpic_pkg::XW-1:0] msWdata,
	output logic                         msAck,
	output logic [cpic_pkg::XW-1:0]      msRdata
);
	import cpic_pkg::*;
	logic [XW-1:0] mem [64];
	logic [XW-1:0] rdat;
	logic [XW-1:0] wrData;
	logic [AW-1:0] wrAddr;
	int            cnt;
	// Released lines show the inverse, never a stale word
	assign msRdata = msAck ? rdat : ~rdat;
	always @(posedge clock or posedge rst) begin
		if (rst) begin
			msAck <= 1'b0;
			cnt <= 0;
			rdat <= '0;
		end else begin
			msAck <= 1'b0;
			if (msReq && !msAck) begin
				if (cnt < LAT) cnt <= cnt + 1;
				else begin
					msAck <= 1'b1;
					cnt <= 0;
					rdat <= mem[msAddr[5:0]];
					if (msWe) mem[msAddr[5:0]] <= msWdata;
					if (msWe) wrAddr <= msAddr;
					if (msWe) wrData <= msWdata;
				end
			end
		end
	end
endmodule : cpic_store_model

// File: tb.sv
// Self-checking bench for the instruction control block
`timescale 1ns/1ps
module tb;
	import cpic_pkg::*;
	typedef struct {logic [2:0] idx; logic [XW-1:0] word; logic [XW-1:0] exp;} cpic_row_t;
	localparam logic [XW-1:0] DATA = {15'h01aa, 15'h0155, 15'h00f0, 15'h010f};
	logic clock = 0, rst = 1, xchgValid = 0, xchgDone = 0;
	logic [2:0] xchgIndex = 3'h0;
	logic [XW-1:0] xchgWord = '0;
	wire msReq, msWe, msAck, running, errorExit, extOutOfRange;
	wire [AW-1:0] msAddr, instrCounter, mainStoreBase, mainStoreLimit, monitorPkgPtr;
	wire [XW-1:0] msWdata, msRdata, xchgOldWord;
	wire [EXW-1:0] errorCause, exitSelect;
	wire [EBW-1:0] extBase, extAbsAddr;
	wire [ELW-1:0] extLimit;
	int n_mismatch = 0, total_checks = 0;
	cpic_row_t rows [7] = '{
		'{XI_CNT, 60'h800_0000_0000_0000, 60'h000_0000_0000_0000},
		'{XI_MSB, 60'h800_0000_0000_0100, 60'h000_0000_0000_0100},
		'{XI_MSL, 60'h800_0000_0000_0004, 60'h000_0000_0000_0004},
		'{XI_SEL, 60'h406_0000_0000_0000, 60'h000_0000_0000_0016},
		'{XI_EXB, 60'h800_0000_00f2_3456, 60'h000_0000_0012_3440},
		'{XI_EXL, 60'h800_0000_0fab_cdef, 60'h000_0000_00ab_cdc0},
		'{XI_MON, 60'h800_0000_0007_1234, 60'h000_0000_0003_1234}};
	always #4 clock = ~clock;
	cpic_instr_ctrl i_cpic_instr_ctrl (.clock(clock), .rst(rst), .xchgValid(xchgValid), .xchgIndex(xchgIndex),
		.xchgWord(xchgWord), .xchgDone(xchgDone), .msAck(msAck), .msRdata(msRdata), .errCpuToCtrl(1'b0),
		.errCtrlToCpu(1'b0), .errFlagParity(1'b0), .msReq(msReq), .msWe(msWe), .msAddr(msAddr),
		.msWdata(msWdata), .xchgOldWord(xchgOldWord), .running(running), .errorExit(errorExit),
		.errorCause(errorCause),
		.instrCounter(instrCounter), .mainStoreBase(mainStoreBase), .mainStoreLimit(mainStoreLimit),
		.exitSelect(exitSelect), .extBase(extBase), .extLimit(extLimit), .monitorPkgPtr(monitorPkgPtr),
		.extAbsAddr(extAbsAddr), .extOutOfRange(extOutOfRange));
	cpic_store_model #(.LAT(2)) i_cpic_store_model (.clock(clock), .rst(rst), .msReq(msReq), .msWe(msWe),
		.msAddr(msAddr), .msWdata(msWdata), .msAck(msAck), .msRdata(msRdata));
	function automatic logic [XW-1:0] pick(input logic [2:0] n);
		case (n)
			XI_CNT: pick = 60'(instrCounter);
			XI_MSB: pick = 60'(mainStoreBase);
			XI_MSL: pick = 60'(mainStoreLimit);
			XI_SEL: pick = 60'(exitSelect);
			XI_EXB: pick = 60'(extBase);
			XI_EXL: pick = 60'(extLimit);
			default: pick = 60'(monitorPkgPtr);
		endcase
	endfunction : pick
	task automatic chk(input string name, input logic [XW-1:0] exp, input logic [XW-1:0] got);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic results();
		$display("Checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : results
	// ==========
	// Sequence
	initial begin
		i_cpic_store_model.mem[0] = {OP_SETA, 3'h1, 6'h00, 15'h0002, OP_XJ, 3'h6, 3'h1, 3'h0, OP_XJ, 9'h000};
		i_cpic_store_model.mem[1] = {OP_SETA, 3'h6, 6'h00, 15'h0003, OP_POP, 3'h7, 3'h0, 3'h6,
		                             OP_XOR, 3'h5, 3'h6, 3'h7};
		i_cpic_store_model.mem[2] = DATA;
		i_cpic_store_model.mem[3] = '0;
		repeat (20) @(posedge clock);
		rst <= 1'b0;
		foreach (rows[n]) begin
			@(posedge clock);
			xchgValid <= 1'b1;
			xchgIndex <= rows[n].idx;
			xchgWord <= rows[n].word;
			@(posedge clock);
			xchgValid <= 1'b0;
			@(negedge clock);
			chk("support", rows[n].exp, pick(rows[n].idx));
		end
		@(posedge clock);
		xchgDone <= 1'b1;
		@(posedge clock);
		xchgDone <= 1'b0;
		for (int c = 0; c < 3000 && errorExit !== 1'b1; c++) @(posedge clock);
		@(negedge clock);
		chk("write addr", 60'(18'h0103), 60'(i_cpic_store_model.wrAddr));
		chk("write data", DATA, i_cpic_store_model.wrData);
		chk("halt", 60'h000_0000_0000_0006, 60'({errorExit, errorCause[EX_RANGE], running}));
		chk("counter", 60'(18'h0004), 60'(instrCounter));
		chk("pop", 60'h000_0000_0000_0013, i_cpic_instr_ctrl.xReg_ff[7]);
		chk("xor", DATA ^ 60'h000_0000_0000_0013, i_cpic_instr_ctrl.xReg_ff[5]);
		chk("ext addr", 60'(21'h12_3440), 60'(extAbsAddr));
		chk("ext range", 60'h0, 60'(extOutOfRange));
		@(posedge clock);
		xchgValid <= 1'b1;
		xchgIndex <= XI_SEL;
		xchgWord <= '0;
		@(posedge clock);
		xchgValid <= 1'b0;
		@(negedge clock);
		chk("old word", 60'h406_0000_0000_0000, xchgOldWord);
		chk("exit clear", 60'h0, 60'({errorExit, exitSelect}));
		// Reset after the halt and exit select exchange clears support state
		@(posedge clock);
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		chk("reset", 60'h0, 60'({instrCounter, mainStoreBase, errorExit}));
		results();
	end
	// Hang guard, far beyond the expected run
	initial begin
		repeat (6000) @(posedge clock);
		n_mismatch++;
		results();
	end
endmodule : tb
